/* shared/oug_defs.vh */
// How it works
// - per-channel 8x and 4x select bits
// - 8x bit picks 8x else 16x
// - 4x bit picks 4x when 8x bit clear
// - config registers reset to zero
// - soft reset bit clears itself
// - soft reset defaults only the channels whose bits are set
// - sleep enable bit per channel
// - no sleep while interrupt pending
// - all asleep stops the oscillator
// - rx byte or modem change wakes
// - ready after 32 crystal clocks
// - wake raises no-source interrupt indicator
// - read-only device type code
// - read-only silicon revision number
// - broadcast bit writes all channels
// - four low bits pick sixteen registers
// - offset zero holding or divisor low
// - offsets one, two divisor or interrupt enable, status
// - offsets 3,4,5,7 fixed registers
// - offset six modem status or delay
// - offset twelve pause char or flags
// - offsets 13-15 write-only, 10-11 reserved
`ifndef OUG_DEFS_VH
`define OUG_DEFS_VH

// ====================================================
// channel register offsets
`define OUG_CH_DATA 4'h0
`define OUG_CH_INTEN 4'h1
`define OUG_CH_INTST 4'h2
`define OUG_CH_LINECTL 4'h3
`define OUG_CH_MODEMCTL 4'h4
`define OUG_CH_LINEST 4'h5
`define OUG_CH_MODEMST 4'h6
`define OUG_CH_SCRATCH 4'h7
`define OUG_CH_FEATURE 4'h8
`define OUG_CH_ENHANCED 4'h9
`define OUG_CH_XOFF1 4'hC
`define OUG_CH_XOFF2 4'hD
`define OUG_CH_XON1 4'hE
`define OUG_CH_XON2 4'hF

// ====================================================
// global register offsets
`define OUG_G_OVS8 4'h0
`define OUG_G_OVS4 4'h1
`define OUG_G_RESET 4'h2
`define OUG_G_SLEEP 4'h3
`define OUG_G_DEVTYPE 4'h4
`define OUG_G_REV 4'h5
`define OUG_G_BCAST 4'h6

// ====================================================
// fields and reset values
`define OUG_ADDR_GLOBAL 7
`define OUG_LINECTL_DLAB 7
`define OUG_BCAST_BIT 0
`define OUG_CFG_W 104
`define OUG_CFG_DLAB 71
`define OUG_REG_RST 8'h00
`define OUG_PIN_IDLE 19'h70000
`define OUG_RATE_16X 2'h0
`define OUG_RATE_8X 2'h1
`define OUG_RATE_4X 2'h2

// ====================================================
// timing
`define OUG_WAKE_CLOCKS 6'h20

`endif

/* logic/oug_chan_regs.v */
`timescale 1ns/1ns
`include "oug_defs.vh"
module oug_chan_regs (
    // clock and reset
    input wire clk,
    input wire ce,
    input wire rst,
    // register access
    input wire wrEn,
    input wire [3:0] wrOffset,
    input wire [7:0] wrData,
    input wire [3:0] rdOffset,
    output reg [7:0] rdData,
    // channel core status
    input wire [7:0] rxHolding,
    input wire [7:0] intStIn,
    input wire [7:0] lineStIn,
    input wire [7:0] modemStIn,
    input wire [7:0] flowFlags,
    // configuration out
    output wire [103:0] cfg,
    output reg txLoad,
    output reg fifoLoad
);
    reg [7:0] divLo, divHi, intEn, lineCtl, modemCtl, rs485, featCtl, enhFn, scratch;
    reg [7:0] xoff1, xoff2, xon1, xon2;
    reg [3:0] divFrac;
    wire dlab;

    assign dlab = lineCtl[`OUG_LINECTL_DLAB];
    assign cfg = {divLo, divHi, 4'h0, divFrac, intEn, lineCtl, modemCtl, rs485, featCtl, enhFn,
                  xoff1, xoff2, xon1, xon2};

    // ====================================================
    // write decode
    always @(posedge clk) begin
        if (rst) begin
            divLo <= `OUG_REG_RST;
            divHi <= `OUG_REG_RST;
            divFrac <= 4'h0;
            intEn <= `OUG_REG_RST;
            lineCtl <= `OUG_REG_RST;
            modemCtl <= `OUG_REG_RST;
            rs485 <= `OUG_REG_RST;
            featCtl <= `OUG_REG_RST;
            enhFn <= `OUG_REG_RST;
            scratch <= `OUG_REG_RST;
            xoff1 <= `OUG_REG_RST;
            xoff2 <= `OUG_REG_RST;
            xon1 <= `OUG_REG_RST;
            xon2 <= `OUG_REG_RST;
            txLoad <= 1'b0;
            fifoLoad <= 1'b0;
        end else if (ce) begin
            txLoad <= 1'b0;
            fifoLoad <= 1'b0;
            if (wrEn) begin
                case (wrOffset)
                    `OUG_CH_DATA: begin
                        if (dlab) divLo <= wrData;
                        else txLoad <= 1'b1;
                    end
                    `OUG_CH_INTEN: begin
                        if (dlab) divHi <= wrData;
                        else intEn <= wrData;
                    end
                    `OUG_CH_INTST: begin
                        if (dlab) divFrac <= wrData[3:0];
                        else fifoLoad <= 1'b1;
                    end
                    `OUG_CH_LINECTL: lineCtl <= wrData;
                    `OUG_CH_MODEMCTL: modemCtl <= wrData;
                    `OUG_CH_SCRATCH: scratch <= wrData;
                    `OUG_CH_MODEMST: rs485 <= wrData;
                    `OUG_CH_FEATURE: featCtl <= wrData;
                    `OUG_CH_ENHANCED: enhFn <= wrData;
                    `OUG_CH_XOFF1: xoff1 <= wrData;
                    `OUG_CH_XOFF2: xoff2 <= wrData;
                    `OUG_CH_XON1: xon1 <= wrData;
                    `OUG_CH_XON2: xon2 <= wrData;
                    default: ;
                endcase
            end
        end
    end

    // ====================================================
    // read mux
    always @* begin
        rdData = `OUG_REG_RST;
        case (rdOffset)
            `OUG_CH_DATA: rdData = dlab ? divLo : rxHolding;
            `OUG_CH_INTEN: rdData = dlab ? divHi : intEn;
            `OUG_CH_INTST: rdData = dlab ? {4'h0, divFrac} : intStIn;
            `OUG_CH_LINECTL: rdData = lineCtl;
            `OUG_CH_MODEMCTL: rdData = modemCtl;
            `OUG_CH_LINEST: rdData = lineStIn;
            `OUG_CH_SCRATCH: rdData = scratch;
            `OUG_CH_MODEMST: rdData = modemStIn;
            `OUG_CH_FEATURE: rdData = featCtl;
            `OUG_CH_ENHANCED: rdData = enhFn;
            `OUG_CH_XOFF1: rdData = flowFlags;
            default: rdData = `OUG_REG_RST;
        endcase
    end
endmodule // oug_chan_regs

/* logic/oug_sleep_ctrl.v */
`timescale 1ns/1ns
`include "oug_defs.vh"
module oug_sleep_ctrl (
    // clock and reset
    input wire clk,
    input wire ce,
    input wire rst,
    // channel inputs
    input wire [7:0] sleepEn,
    input wire [7:0] intPending,
    input wire [7:0] wakeEvent,
    input wire [7:0] intStRead,
    // state out
    output reg [7:0] asleep,
    output reg oscStop,
    output reg [7:0] wakeIntr,
    output reg ready
);
    reg [5:0] wakeCnt;
    wire [7:0] next_asleep;
    wire wakeNow;

    assign next_asleep = sleepEn & ~intPending & ~wakeIntr & ~wakeEvent;
    // any rx byte, modem change or cleared sleep enable
    assign wakeNow = oscStop & ((|wakeEvent) | ~(&sleepEn));

    always @(posedge clk) begin
        if (rst) begin
            asleep <= 8'h00;
            oscStop <= 1'b0;
            wakeIntr <= 8'h00;
            ready <= 1'b1;
            wakeCnt <= 6'h00;
        end else if (ce) begin
            wakeIntr <= (wakeIntr & ~intStRead) | (wakeNow ? asleep : 8'h00);
            if (wakeNow) begin
                oscStop <= 1'b0;
                asleep <= 8'h00;
                wakeCnt <= `OUG_WAKE_CLOCKS;
                ready <= 1'b0;
            end else if (wakeCnt != 6'h00) begin
                wakeCnt <= wakeCnt - 6'h01;
                ready <= (wakeCnt == 6'h01);
            end else if (!oscStop) begin
                asleep <= next_asleep;
                oscStop <= &next_asleep;
            end
        end
    end
endmodule // oug_sleep_ctrl

/* logic/oug_top.v */
`timescale 1ns/1ns
`include "oug_defs.vh"
module oug_top #(
    // arbitrary neutral identity values
    parameter [7:0] DEV_TYPE = 8'h3C,
    parameter [7:0] REVISION = 8'h03
) (
    // clock, enable and reset
    input wire clk,
    input wire ce,
    input wire rst,
    // host bus pins
    input wire csN,
    input wire iorN,
    input wire iowN,
    input wire [7:0] addr,
    input wire [7:0] dataIn,
    output reg [7:0] dataOut,
    output reg dataOe,
    // channel core status, eight bytes each; pending and wake one bit per channel
    input wire [63:0] rxHolding,
    input wire [63:0] intStatus,
    input wire [63:0] lineStatus,
    input wire [63:0] modemStatus,
    input wire [63:0] flowFlags,
    input wire [7:0] intPending,
    input wire [7:0] wakeEvent,
    // channel configuration
    output wire [831:0] chanCfg,
    output wire [7:0] txLoad,
    output wire [7:0] fifoLoad,
    output reg [7:0] busWrData,
    // read side effects
    output reg [7:0] rxRead,
    output reg [7:0] intStRead,
    output reg [7:0] lineStRead,
    output reg [7:0] modemStRead,
    // global control
    output reg [7:0] chanReset,
    output reg [15:0] sampleRate,
    // power state
    output wire [7:0] chanAsleep,
    output wire oscStop,
    output wire [7:0] wakeIntr,
    output wire wakeReady
);
    // ====================================================
    // decode helpers
    function [7:0] chanOneHot;
        input [2:0] ch;
        begin
            chanOneHot = 8'h01 << ch;
        end
    endfunction

    function [1:0] rateCode;
        input sel8;
        input sel4;
        begin
            if (sel8) rateCode = `OUG_RATE_8X;
            else if (sel4) rateCode = `OUG_RATE_4X;
            else rateCode = `OUG_RATE_16X;
        end
    endfunction

    // ====================================================
    // pin synchronisers
    reg [18:0] pinMeta;
    reg [18:0] pinSync;

    always @(posedge clk) begin
        if (rst) begin
            pinMeta <= `OUG_PIN_IDLE;
            pinSync <= `OUG_PIN_IDLE;
        end else if (ce) begin
            pinMeta <= {csN, iorN, iowN, addr, dataIn};
            pinSync <= pinMeta;
        end
    end

    wire csS;
    wire iorS;
    wire iowS;
    wire [7:0] addrS;
    wire [7:0] dataS;
    assign csS = pinSync[18];
    assign iorS = pinSync[17];
    assign iowS = pinSync[16];
    assign addrS = pinSync[15:8];
    assign dataS = pinSync[7:0];

    // ====================================================
    // strobe tracking
    reg rdPrev;
    reg wrPrev;
    reg [7:0] holdAddr;
    reg [7:0] holdData;
    wire rdAct;
    wire wrAct;
    wire rdStart;
    wire wrCommit;

    assign rdAct = ~csS & ~iorS;
    assign wrAct = ~csS & ~iowS;
    assign rdStart = rdAct & ~rdPrev;
    assign wrCommit = wrPrev & ~wrAct;

    always @(posedge clk) begin
        if (rst) begin
            rdPrev <= 1'b0;
            wrPrev <= 1'b0;
            holdAddr <= 8'h00;
            holdData <= 8'h00;
        end else if (ce) begin
            rdPrev <= rdAct;
            wrPrev <= wrAct;
            if (wrAct) begin
                holdAddr <= addrS;
                holdData <= dataS;
            end
        end
    end

    // ====================================================
    // global registers
    reg [7:0] ovs8;
    reg [7:0] ovs4;
    reg [7:0] sleepEn;
    reg bcast;
    wire wrGlobal;
    wire rdGlobal;

    assign wrGlobal = wrCommit & holdAddr[`OUG_ADDR_GLOBAL];
    assign rdGlobal = addrS[`OUG_ADDR_GLOBAL];

    always @(posedge clk) begin
        if (rst) begin
            ovs8 <= `OUG_REG_RST;
            ovs4 <= `OUG_REG_RST;
            chanReset <= `OUG_REG_RST;
            sleepEn <= `OUG_REG_RST;
            bcast <= 1'b0;
        end else if (ce) begin
            chanReset <= `OUG_REG_RST;
            if (wrGlobal) begin
                case (holdAddr[3:0])
                    `OUG_G_OVS8: ovs8 <= holdData;
                    `OUG_G_OVS4: ovs4 <= holdData;
                    `OUG_G_RESET: chanReset <= holdData;
                    `OUG_G_SLEEP: sleepEn <= holdData;
                    `OUG_G_BCAST: bcast <= holdData[`OUG_BCAST_BIT];
                    default: ;
                endcase
            end
        end
    end

    // ====================================================
    // sampling rate per channel
    integer i;

    always @(posedge clk) begin
        if (rst) begin
            sampleRate <= 16'h0000;
        end else if (ce) begin
            for (i = 0; i < 8; i = i + 1) begin
                sampleRate[i*2 +: 2] <= rateCode(ovs8[i], ovs4[i]);
            end
        end
    end

    // ====================================================
    // channel register banks
    wire [7:0] wrChan;
    wire [63:0] chanRd;
    wire [7:0] chanDlab;
    wire [7:0] wakeMask;

    assign wrChan = (wrCommit & ~holdAddr[`OUG_ADDR_GLOBAL]) ?
                    (bcast ? 8'hFF : chanOneHot(holdAddr[6:4])) : 8'h00;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : chan
            wire [7:0] intView;

            assign intView = wakeMask[g] ? {intStatus[g*8+4 +: 4], 4'h0} :
                             intStatus[g*8 +: 8];
            assign chanDlab[g] = chanCfg[g*`OUG_CFG_W + `OUG_CFG_DLAB];

            oug_chan_regs regs (
                .clk(clk),
                .ce(ce),
                .rst(rst | chanReset[g]),
                .wrEn(wrChan[g]),
                .wrOffset(holdAddr[3:0]),
                .wrData(holdData),
                .rdOffset(addrS[3:0]),
                .rdData(chanRd[g*8 +: 8]),
                .rxHolding(rxHolding[g*8 +: 8]),
                .intStIn(intView),
                .lineStIn(lineStatus[g*8 +: 8]),
                .modemStIn(modemStatus[g*8 +: 8]),
                .flowFlags(flowFlags[g*8 +: 8]),
                .cfg(chanCfg[g*`OUG_CFG_W +: `OUG_CFG_W]),
                .txLoad(txLoad[g]),
                .fifoLoad(fifoLoad[g])
            );
        end
    endgenerate

    // ====================================================
    // host read path
    reg [7:0] globalRd;
    wire [7:0] rdSel;
    wire rdDlab;

    assign rdSel = chanOneHot(addrS[6:4]);
    assign rdDlab = chanDlab[addrS[6:4]];

    always @* begin
        globalRd = `OUG_REG_RST;
        case (addrS[3:0])
            `OUG_G_OVS8: globalRd = ovs8;
            `OUG_G_OVS4: globalRd = ovs4;
            `OUG_G_RESET: globalRd = chanReset;
            `OUG_G_SLEEP: globalRd = sleepEn;
            `OUG_G_DEVTYPE: globalRd = DEV_TYPE;
            `OUG_G_REV: globalRd = REVISION;
            `OUG_G_BCAST: globalRd = {7'h00, bcast};
            default: globalRd = `OUG_REG_RST;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            dataOut <= 8'h00;
            dataOe <= 1'b0;
            rxRead <= 8'h00;
            intStRead <= 8'h00;
            lineStRead <= 8'h00;
            modemStRead <= 8'h00;
            busWrData <= 8'h00;
        end else if (ce) begin
            dataOe <= rdAct;
            rxRead <= 8'h00;
            intStRead <= 8'h00;
            lineStRead <= 8'h00;
            modemStRead <= 8'h00;
            if (wrCommit) begin
                busWrData <= holdData;
            end
            if (rdStart) begin
                if (rdGlobal) begin
                    dataOut <= globalRd;
                end else begin
                    dataOut <= chanRd[addrS[6:4]*8 +: 8];
                    if (addrS[3:0] == `OUG_CH_DATA && !rdDlab) rxRead <= rdSel;
                    if (addrS[3:0] == `OUG_CH_INTST && !rdDlab) intStRead <= rdSel;
                    if (addrS[3:0] == `OUG_CH_LINEST) lineStRead <= rdSel;
                    if (addrS[3:0] == `OUG_CH_MODEMST) modemStRead <= rdSel;
                end
            end
        end
    end

    // ====================================================
    // sleep and oscillator control
    // oscillator stop when all asleep
    oug_sleep_ctrl sleep (
        .clk(clk),
        .ce(ce),
        .rst(rst),
        .sleepEn(sleepEn),
        .intPending(intPending),
        .wakeEvent(wakeEvent),
        .intStRead(intStRead),
        .asleep(chanAsleep),
        .oscStop(oscStop),
        .wakeIntr(wakeMask),
        .ready(wakeReady)
    );

    assign wakeIntr = wakeMask;

endmodule // oug_top

/* tb/oug_top_assertions.sv */
`timescale 1ns/1ns
// ====================================================
// checker on the top ports
module oug_top_checker (
    // clock and reset
    input wire clk,
    input wire rst,
    // host bus
    input wire csN,
    input wire iorN,
    input wire dataOe,
    // channel side
    input wire [7:0] intPending,
    input wire [831:0] chanCfg,
    input wire [7:0] txLoad,
    input wire [7:0] rxRead,
    input wire [7:0] intStRead,
    input wire [7:0] lineStRead,
    input wire [7:0] modemStRead,
    // global control and power
    input wire [7:0] chanReset,
    input wire [15:0] sampleRate,
    input wire [7:0] chanAsleep,
    input wire oscStop,
    input wire [7:0] wakeIntr,
    input wire wakeReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire [7:0] anyPulse = txLoad | rxRead | intStRead | lineStRead | modemStRead;
    sequence s_read_held;
        (!csN && !iorN) [*5];
    endsequence
    sequence s_bus_idle;
        csN [*5];
    endsequence
    sequence s_wake_count;
        ##31 !wakeReady ##1 wakeReady;
    endsequence
    a_oe_on_read: assert property (s_read_held |-> dataOe)
        else $error("data bus not driven during read");
    a_oe_released: assert property (s_bus_idle |-> !dataOe)
        else $error("data bus driven while deselected");
    a_reset_self_clear: assert property (|chanReset |=> chanReset == 8'h00)
        else $error("soft reset bit stayed set");
    a_rate_legal: assert property (((sampleRate >> 1) & sampleRate & 16'h5555) == 16'h0000)
        else $error("illegal sampling rate code");
    a_osc_all_asleep: assert property ($rose(oscStop) |-> chanAsleep == 8'hFF)
        else $error("oscillator stopped with a channel awake");
    a_no_sleep_pending: assert property (!$past(oscStop) |-> (chanAsleep & $past(intPending)) == 8'h00)
        else $error("channel asleep with interrupt pending");
    a_wake_flags: assert property ($fell(oscStop) |-> wakeIntr == 8'hFF && chanAsleep == 8'h00 && !wakeReady)
        else $error("wake indicators wrong");
    a_wake_count: assert property ($fell(wakeReady) |-> s_wake_count)
        else $error("wake ready count not 32");
    a_pulse_single: assert property (|anyPulse |=> anyPulse == 8'h00)
        else $error("access pulse longer than one cycle");
    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1) begin : g_ch
            a_soft_rst_clears: assert property (chanReset[n] |=> chanCfg[104*n+:104] == 104'h0)
                else $error("channel config not cleared");
        end
    endgenerate
endmodule // oug_top_checker

bind oug_top oug_top_checker i_oug_top_checker (.clk(clk), .rst(rst), .csN(csN), .iorN(iorN),
    .dataOe(dataOe), .intPending(intPending), .chanCfg(chanCfg), .txLoad(txLoad),
    .rxRead(rxRead), .intStRead(intStRead), .lineStRead(lineStRead),
    .modemStRead(modemStRead),
    .chanReset(chanReset), .sampleRate(sampleRate), .chanAsleep(chanAsleep),
    .oscStop(oscStop), .wakeIntr(wakeIntr), .wakeReady(wakeReady));

/* tb/oug_host_model.sv */
`timescale 1ns/1ns
// ====================================================
// host processor on the parallel bus
module oug_host_model (
    // clock
    input wire clk,
    // host bus pins
    output logic csN,
    output logic iorN,
    output logic iowN,
    output logic [7:0] addr,
    output logic [7:0] dataIn,
    input wire [7:0] dataOut
);
    initial begin
        csN = 1'b1;
        iorN = 1'b1;
        iowN = 1'b1;
        addr = 8'h00;
        dataIn = 8'h00;
    end
    task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        dataIn = d;
        csN = 1'b0;
        iowN = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        csN = 1'b1;
        iowN = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        dataIn = ~d;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic busRead(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        csN = 1'b0;
        iorN = 1'b0;
        repeat (5) @(posedge clk);
        d = dataOut;
        #1;
        csN = 1'b1;
        iorN = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask
endmodule // oug_host_model

/* tb/test_oug_top.sv */
`timescale 1ns/1ns
module test_oug_top;
    // ====================================================
    // stimulus and design outputs
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [63:0] rxHolding, intStatus, lineStatus, modemStatus, flowFlags;
    logic [7:0] intPending = 8'h00;
    logic [7:0] wakeEvent = 8'h00;
    wire csN, iorN, iowN, dataOe, oscStop, wakeReady;
    wire [7:0] addr, dataIn, dataOut, txLoad, chanReset, chanAsleep, wakeIntr;
    wire [831:0] chanCfg;
    wire [7:0] fifoLoad, busWrData;
    logic [7:0] fifoSeen;
    wire [15:0] sampleRate;
    integer seed = 61;
    int nMismatch = 0;
    int checked = 0;
    int ch, k, n;
    logic [7:0] txSeen, rstSeen, rd, v8, v4, base;
    logic [7:0] wv [16];
    logic [7:0] dv [3];
    always #20 clk = ~clk;
    always @(posedge clk) begin
        txSeen <= txSeen | txLoad;
        fifoSeen <= fifoSeen | fifoLoad;
        rstSeen <= rstSeen | chanReset;
    end
    // arbitrary identity values
    oug_top #(.DEV_TYPE(8'h3C), .REVISION(8'h03)) i_oug_top (.clk(clk), .ce(1'b1), .rst(rst),
        .csN(csN), .iorN(iorN), .iowN(iowN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .rxHolding(rxHolding), .intStatus(intStatus), .lineStatus(lineStatus),
        .modemStatus(modemStatus), .flowFlags(flowFlags), .intPending(intPending),
        .wakeEvent(wakeEvent), .chanCfg(chanCfg), .txLoad(txLoad), .fifoLoad(fifoLoad),
        .busWrData(busWrData), .rxRead(), .intStRead(), .lineStRead(), .modemStRead(),
        .chanReset(chanReset),
        .sampleRate(sampleRate), .chanAsleep(chanAsleep), .oscStop(oscStop),
        .wakeIntr(wakeIntr), .wakeReady(wakeReady));
    oug_host_model i_oug_host_model (.clk(clk), .csN(csN), .iorN(iorN), .iowN(iowN),
        .addr(addr), .dataIn(dataIn), .dataOut(dataOut));
    // ====================================================
    // helpers
    task wr(input logic [7:0] a, input logic [7:0] d);
        i_oug_host_model.busWrite(a, d);
    endtask
    task rdb(input logic [7:0] a);
        i_oug_host_model.busRead(a, rd);
    endtask
    task check(input logic [103:0] got, input logic [103:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finalReport;
        $display("mismatches %0d comparisons %0d", nMismatch, checked);
        if (nMismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [15:0] rateOf(input logic [7:0] a8, input logic [7:0] a4);
        for (int i = 0; i < 8; i++) begin
            rateOf[2*i+:2] = a8[i] ? 2'h1 : (a4[i] ? 2'h2 : 2'h0);
        end
    endfunction
    function automatic logic [7:0] expRead(input int o, input int c, input logic [7:0] w);
        case (o)
            0: return rxHolding[8*c+:8];
            2: return intStatus[8*c+:8];
            3: return 8'h03;
            5: return lineStatus[8*c+:8];
            6: return modemStatus[8*c+:8];
            12: return flowFlags[8*c+:8];
            1, 4, 7, 8, 9: return w;
            default: return 8'h00;
        endcase
    endfunction
    function automatic int cfgIdx(input int o);
        case (o)
            1: return 9;
            4: return 7;
            6: return 6;
            8: return 5;
            9: return 4;
            12: return 3;
            13: return 2;
            14: return 1;
            15: return 0;
            default: return -1;
        endcase
    endfunction
    // ====================================================
    // main sequence
    initial begin
        rxHolding = {$random(seed), $random(seed)};
        intStatus = {$random(seed), $random(seed)};
        lineStatus = {$random(seed), $random(seed)};
        modemStatus = {$random(seed), $random(seed)};
        flowFlags = {$random(seed), $random(seed)};
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        wr(8'h84, 8'hFF);
        for (int g = 0; g < 8; g++) begin
            rdb(8'h80 | g[7:0]);
            check(rd, g == 4 ? 8'h3C : (g == 5 ? 8'h03 : 8'h00));
        end
        for (k = 0; k < 6; k++) begin
            v8 = (k == 0) ? 8'h00 : $random(seed);
            v4 = (k == 5) ? 8'h00 : $random(seed);
            wr(8'h80, v8);
            wr(8'h81, v4);
            check(sampleRate, rateOf(v8, v4));
        end
        rdb(8'h80);
        check(rd, v8);
        ch = {$random(seed)} % 8;
        base = {1'b0, ch[2:0], 4'h0};
        wr(base | 8'h03, 8'h80);
        for (int i = 0; i < 3; i++) begin
            dv[i] = $random(seed);
            wr(base | i[7:0], dv[i]);
        end
        for (int i = 0; i < 3; i++) begin
            rdb(base | i[7:0]);
            check(rd, i == 2 ? dv[i] & 8'h0F : dv[i]);
        end
        wr(base | 8'h03, 8'h03);
        txSeen = 8'h00;
        fifoSeen = 8'h00;
        for (int o = 0; o < 16; o++) begin
            wv[o] = $random(seed);
            if (o != 3) wr(base | o[7:0], wv[o]);
        end
        for (int o = 0; o < 16; o++) begin
            rdb(base | o[7:0]);
            check(rd, expRead(o, ch, wv[o]));
            if (cfgIdx(o) >= 0) check(chanCfg[104*ch+8*cfgIdx(o)+:8], wv[o]);
        end
        check(txSeen, 8'h01 << ch);
        check(fifoSeen, 8'h01 << ch);
        check(chanCfg[104*ch+80+:24], {dv[0], dv[1], 4'h0, dv[2][3:0]});
        wr(8'h86, 8'h01);
        txSeen = 8'h00;
        wr(8'h24, 8'hA5);
        wr(8'h20, 8'h5A);
        check(busWrData, 8'h5A);
        check(txSeen, 8'hFF);
        for (int c = 0; c < 8; c++) check(chanCfg[104*c+56+:8], 8'hA5);
        wr(8'h86, 8'h00);
        k = {$random(seed)} % 8;
        rstSeen = 8'h00;
        wr(8'h82, 8'h01 << k);
        check(rstSeen, 8'h01 << k);
        check(chanCfg[104*k+:104], 104'h0);
        check(chanCfg[104*((k+1)%8)+56+:8], 8'hA5);
        rdb(8'h82);
        check(rd, 8'h00);
        intPending = 8'h08;
        wr(8'h83, 8'hFF);
        check(chanAsleep, 8'hF7);
        check(oscStop, 1'b0);
        intPending = 8'h00;
        repeat (2) @(posedge clk);
        #1;
        check(oscStop, 1'b1);
        wakeEvent = 8'h20;
        @(posedge clk);
        #1;
        wakeEvent = 8'h00;
        check({oscStop, wakeIntr, wakeReady}, 10'h1FE);
        for (n = 0; n < 100 && wakeReady !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 100) begin
            nMismatch++;
            finalReport();
        end
        check(n, 32);
        rdb(8'h52);
        check(rd, intStatus[47:40] & 8'hF0);
        check(wakeIntr, 8'hDF);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check({sampleRate, chanAsleep}, 24'h0);
        repeat (3) @(posedge clk);
        rdb(8'h83);
        check(rd, 8'h00);
        finalReport();
    end
endmodule // test_oug_top
